// [kli_pkg.sv]
// Shared constants, register map and decode for the keypad level interrupt unit
`default_nettype none

package kli_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int KLI_LINES = 8;
    localparam int KLI_AW    = 8;
    localparam int KLI_DW    = 8;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [KLI_AW-1:0] KLI_ADDR_LEVEL_SEL  = 8'h9C;
    localparam logic [KLI_AW-1:0] KLI_ADDR_LINE_EN    = 8'h9D;
    localparam logic [KLI_AW-1:0] KLI_ADDR_LINE_FLAGS = 8'h9E;
    localparam logic [KLI_AW-1:0] KLI_ADDR_CTRL       = 8'h9F;
    localparam logic [KLI_AW-1:0] KLI_ADDR_LINE_STATE = 8'hA0;

    // ************************************************************
    // Reset values and fields
    // ************************************************************
    localparam logic [KLI_DW-1:0] KLI_RST_LEVEL_SEL  = 8'h00;
    localparam logic [KLI_DW-1:0] KLI_RST_LINE_EN    = 8'h00;
    localparam logic [KLI_DW-1:0] KLI_RST_LINE_FLAGS = 8'h00;
    localparam logic [KLI_DW-1:0] KLI_RST_CTRL       = 8'h00;
    localparam logic [KLI_DW-1:0] KLI_READ_IDLE      = 8'h00;
    localparam int                KLI_CTRL_GLOBAL_EN = 0;

    // ************************************************************
    // Register decode
    // ************************************************************
    typedef enum logic [2:0] {
        KLI_REG_NONE  = 3'b000,
        KLI_REG_LEVEL = 3'b001,
        KLI_REG_EN    = 3'b010,
        KLI_REG_FLAGS = 3'b011,
        KLI_REG_CTRL  = 3'b100,
        KLI_REG_STATE = 3'b101
    } kli_reg_t;

    function automatic kli_reg_t kli_decode(input logic [KLI_AW-1:0] addr);
        kli_reg_t r;
        r = KLI_REG_NONE;
        if (addr == KLI_ADDR_LEVEL_SEL) begin
            r = KLI_REG_LEVEL;
        end else if (addr == KLI_ADDR_LINE_EN) begin
            r = KLI_REG_EN;
        end else if (addr == KLI_ADDR_LINE_FLAGS) begin
            r = KLI_REG_FLAGS;
        end else if (addr == KLI_ADDR_CTRL) begin
            r = KLI_REG_CTRL;
        end else if (addr == KLI_ADDR_LINE_STATE) begin
            r = KLI_REG_STATE;
        end
        return r;
    endfunction

endpackage

`default_nettype wire

// [kli_det_if.sv]
// Carrier between the register block and the line level detector
`default_nettype none

interface kli_det_if #(
    parameter int N = 8
);
    logic [N-1:0] level_sel;
    logic [N-1:0] lines;
    logic [N-1:0] match;

    modport det (input level_sel, input lines, output match);
    modport ctl (output level_sel, output lines, input match);
endinterface

`default_nettype wire

// [kli_line_detect.sv]
// Per-line level comparator, registered once per system clock
`default_nettype none

module kli_line_detect
    import kli_pkg::*;
#(
    parameter int N = KLI_LINES
) (
    input  wire logic i_clk_sys,   // System clock
    input  wire logic i_rst,       // Synchronous reset, active high
    kli_det_if.det    det          // Level selects in, matches out
);

    // ************************************************************
    // Level compare
    // ************************************************************
    function automatic logic level_hit(input logic line, input logic sel);
        // Select one asks for a high level, zero for a low level
        return line == sel;
    endfunction

    logic [N-1:0] match_q;
    logic [N-1:0] next_match;

    always_comb begin
        next_match = match_q;
        for (int k = 0; k < N; k++) begin
            next_match[k] = level_hit(det.lines[k], det.level_sel[k]);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            match_q <= '0;
        end else begin
            match_q <= next_match;
        end
    end

    assign det.match = match_q;

endmodule

`default_nettype wire

// [kli_keypad_irq.sv]
// Keypad level interrupt unit: line flags, enables, level selects and shared request
//
// Behaviour
// - Each line sets its flag whenever its input shows the selected level.
// - Request is the OR over lines of flag AND that line's enable.
// - Enable zero leaves the pin plain I/O; its flag then raises no request.
// - Level select zero detects low, one detects high, per line.
// - Flag, enable and level select registers all read zero after reset.
// - Level select at 9Ch, enables at 9Dh, flags at 9Eh; bit n is line n.
// - A global keypad enable gates the shared request toward the interrupt system.
// - All lines share one request; software reads flags to find the source.
// - A selected level on an enabled line raises a wake request while the global keypad enable is set.
//
// Decided for this implementation: the strobed register port.
`default_nettype none

module kli_keypad_irq
    import kli_pkg::*;
#(
    parameter int N = KLI_LINES
) (
    input  wire logic              i_clk_sys,   // System clock, 40 MHz
    input  wire logic              i_rst,       // Synchronous reset, active high
    input  wire logic [N-1:0]      i_lines,     // Keypad port input lines
    input  wire logic [KLI_AW-1:0] i_addr,      // Register address
    input  wire logic [KLI_DW-1:0] i_wdata,     // Register write data
    input  wire logic              i_wr,        // Write strobe
    input  wire logic              i_rd,        // Read strobe
    output logic      [KLI_DW-1:0] o_rdata,     // Read data, the cycle after the read strobe
    output logic                   o_irq,       // Shared keypad interrupt request, level
    output logic                   o_wake,      // Wake request for idle and power-down
    output logic      [N-1:0]      o_key_mode   // Per line: one while the pin serves the keypad
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // Registers are one byte wide, so more lines have no bits to live in
    if (N < 1 || N > KLI_DW) begin : g_bad_lines
        $error("kli_keypad_irq: N must lie between 1 and the register width");
    end

    // The global enable must be a real bit of the control register
    if (KLI_CTRL_GLOBAL_EN < 0 || KLI_CTRL_GLOBAL_EN >= KLI_DW) begin : g_bad_ctrl_bit
        $error("kli_keypad_irq: global enable bit lies outside the control register");
    end

    // A shared address would let one write land in two registers
    if (KLI_ADDR_LEVEL_SEL == KLI_ADDR_LINE_EN
        || KLI_ADDR_LEVEL_SEL == KLI_ADDR_LINE_FLAGS
        || KLI_ADDR_LEVEL_SEL == KLI_ADDR_CTRL
        || KLI_ADDR_LEVEL_SEL == KLI_ADDR_LINE_STATE
        || KLI_ADDR_LINE_EN == KLI_ADDR_LINE_FLAGS
        || KLI_ADDR_LINE_EN == KLI_ADDR_CTRL
        || KLI_ADDR_LINE_EN == KLI_ADDR_LINE_STATE
        || KLI_ADDR_LINE_FLAGS == KLI_ADDR_CTRL
        || KLI_ADDR_LINE_FLAGS == KLI_ADDR_LINE_STATE
        || KLI_ADDR_CTRL == KLI_ADDR_LINE_STATE) begin : g_bad_map
        $error("kli_keypad_irq: two registers share one address");
    end

    // The decode table must send each mapped address to its own register
    if (kli_decode(KLI_ADDR_LEVEL_SEL) != KLI_REG_LEVEL
        || kli_decode(KLI_ADDR_LINE_EN) != KLI_REG_EN
        || kli_decode(KLI_ADDR_LINE_FLAGS) != KLI_REG_FLAGS
        || kli_decode(KLI_ADDR_CTRL) != KLI_REG_CTRL
        || kli_decode(KLI_ADDR_LINE_STATE) != KLI_REG_STATE) begin : g_bad_decode
        $error("kli_keypad_irq: register decode does not match the address map");
    end

    // Reset values may only use bits that a line owns
    if (((KLI_RST_LEVEL_SEL | KLI_RST_LINE_EN | KLI_RST_LINE_FLAGS) >> N) != '0) begin : g_bad_reset
        $error("kli_keypad_irq: a reset value sets a bit above the last line");
    end

    // ************************************************************
    // Register map
    // ************************************************************
    //   Offset  Register       Access  Reset  Bit n
    //   9Ch     level select   RW      00h    1 detects high, 0 detects low on line n
    //   9Dh     line enable    RW      00h    1 lets flag n ask for service
    //   9Eh     line flags     W1C     00h    set by the level on line n, write one to clear
    //   9Fh     control        RW      00h    bit 0 only: global keypad enable
    //   A0h     line state     RO      -      registered match of line n
    //   Other addresses: writes dropped, reads give 00h
    //
    // Latency from a line reaching its level, in rising edges:
    //   1  match register
    //   2  flag, and wake when the line and the block are enabled
    //   3  request, when flag, line enable and global enable are all set
    //   Clear: a one written takes effect at its edge, the request falls one edge later
    //
    // Limitation: wake leaves a flip-flop, so the clock must keep running in power-down
    //
    // Bus: a strobe is taken at the rising edge where it is high
    // Read data stand in the next cycle only; idle read data are zero
    // A read right after a write sees the new value

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [KLI_DW-1:0] widen(input logic [N-1:0] v);
        // Unused upper bits always read as zero
        return KLI_DW'(v);
    endfunction

    function automatic logic [N-1:0] narrow(input logic [KLI_DW-1:0] v);
        return v[N-1:0];
    endfunction

    // ************************************************************
    // Bus decode
    // ************************************************************
    kli_reg_t wr_sel;
    kli_reg_t rd_sel;

    assign wr_sel = i_wr ? kli_decode(i_addr) : KLI_REG_NONE;
    assign rd_sel = i_rd ? kli_decode(i_addr) : KLI_REG_NONE;

    // ************************************************************
    // Level detector
    // ************************************************************
    kli_det_if #(.N(N)) det_bus ();

    logic [N-1:0] level_sel;
    logic [N-1:0] line_en;
    logic [N-1:0] line_flags;
    logic         global_en;

    assign det_bus.level_sel = level_sel;
    assign det_bus.lines     = i_lines;

    kli_line_detect #(
        .N (N)
    ) u_detect (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .det       (det_bus)
    );

    // ************************************************************
    // Per-line pending terms
    // ************************************************************
    logic [N-1:0] line_pending;
    logic [N-1:0] line_wake;

    for (genvar g = 0; g < N; g++) begin : g_line
        // A disabled line keeps its flag but never asks for service
        assign line_pending[g] = line_flags[g] & line_en[g];
        assign line_wake[g]    = det_bus.match[g] & line_en[g];
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [N-1:0] next_level_sel;
    logic [N-1:0] next_line_en;
    logic [N-1:0] next_line_flags;
    logic         next_global_en;
    logic [N-1:0] flag_clear;
    logic [N-1:0] flag_set;

    always_comb begin
        next_level_sel  = level_sel;
        next_line_en    = line_en;
        next_global_en  = global_en;
        flag_clear      = '0;
        unique case (wr_sel)
            KLI_REG_LEVEL: begin
                next_level_sel = narrow(i_wdata);
            end
            KLI_REG_EN: begin
                next_line_en = narrow(i_wdata);
            end
            KLI_REG_FLAGS: begin
                // Writing a one clears that flag, zeros leave flags alone
                flag_clear = narrow(i_wdata);
            end
            KLI_REG_CTRL: begin
                next_global_en = i_wdata[KLI_CTRL_GLOBAL_EN];
            end
            KLI_REG_STATE,
            KLI_REG_NONE: begin
                // Line state is read only; unmapped writes are dropped
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            level_sel  <= narrow(KLI_RST_LEVEL_SEL);
            line_en    <= narrow(KLI_RST_LINE_EN);
            global_en  <= KLI_RST_CTRL[KLI_CTRL_GLOBAL_EN];
        end else begin
            level_sel  <= next_level_sel;
            line_en    <= next_line_en;
            global_en  <= next_global_en;
        end
    end

    // ************************************************************
    // Line flags
    // ************************************************************
    // Flags are set whether or not the line is enabled; enable only gates service
    always_comb begin
        flag_set        = det_bus.match;
        // A level seen in the clearing cycle wins, so no key press is lost
        next_line_flags = (line_flags & ~flag_clear) | flag_set;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            line_flags <= narrow(KLI_RST_LINE_FLAGS);
        end else begin
            line_flags <= next_line_flags;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Data stand for one cycle only, so a held value is never mistaken for a new read
    logic [KLI_DW-1:0] rdata_q;
    logic [KLI_DW-1:0] next_rdata;

    always_comb begin
        next_rdata = KLI_READ_IDLE;
        unique case (rd_sel)
            KLI_REG_LEVEL: begin
                next_rdata = widen(level_sel);
            end
            KLI_REG_EN: begin
                next_rdata = widen(line_en);
            end
            KLI_REG_FLAGS: begin
                // Software walks these bits to find which line asked
                next_rdata = widen(line_flags);
            end
            KLI_REG_CTRL: begin
                next_rdata = KLI_READ_IDLE;
                next_rdata[KLI_CTRL_GLOBAL_EN] = global_en;
            end
            KLI_REG_STATE: begin
                next_rdata = widen(det_bus.match);
            end
            KLI_REG_NONE: begin
                next_rdata = KLI_READ_IDLE;
            end
            default: begin
                next_rdata = KLI_READ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_q <= KLI_READ_IDLE;
        end else begin
            rdata_q <= next_rdata;
        end
    end

    assign o_rdata = rdata_q;

    // ************************************************************
    // Request and pin outputs
    // ************************************************************
    // Request costs one cycle of latency so every output leaves a flip-flop
    logic         irq_q;
    logic         wake_q;
    logic [N-1:0] key_mode_q;
    logic         next_irq;
    logic         next_wake;
    logic [N-1:0] next_key_mode;

    always_comb begin
        next_irq      = global_en & (|line_pending);
        // Wake does not wait for the flag, so a clock-stopped core can still be roused
        next_wake     = global_en & (|line_wake);
        next_key_mode = line_en;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_q      <= 1'b0;
            wake_q     <= 1'b0;
            key_mode_q <= '0;
        end else begin
            irq_q      <= next_irq;
            wake_q     <= next_wake;
            key_mode_q <= next_key_mode;
        end
    end

    assign o_irq      = irq_q;
    assign o_wake     = wake_q;
    assign o_key_mode = key_mode_q;

endmodule

`default_nettype wire

// [kli_checker.sv]
// Port-level assertions for the keypad level interrupt unit
`default_nettype none
module kli_checker
    import kli_pkg::*;
#(
    parameter int N = KLI_LINES
) (
    input wire logic              i_clk_sys, // Clock
    input wire logic              i_rst,     // Reset
    input wire logic [N-1:0]      i_lines,   // Lines
    input wire logic [KLI_AW-1:0] i_addr,    // Address
    input wire logic [KLI_DW-1:0] i_wdata,   // Write data
    input wire logic              i_wr,      // Write strobe
    input wire logic              i_rd,      // Read strobe
    input wire logic [KLI_DW-1:0] o_rdata,   // Read data
    input wire logic              o_irq,     // Request
    input wire logic              o_wake,    // Wake
    input wire logic [N-1:0]      o_key_mode // Keypad mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Shadow registers, rebuilt from bus writes
    // ********
    logic [N-1:0] sel, en, mt, fl, next_sel, next_en, next_fl;
    logic         g, next_g, irq_r, wake_r;
    always_comb begin
        next_sel = (i_wr && i_addr == KLI_ADDR_LEVEL_SEL) ? i_wdata[N-1:0] : sel;
        next_en = (i_wr && i_addr == KLI_ADDR_LINE_EN) ? i_wdata[N-1:0] : en;
        next_g = (i_wr && i_addr == KLI_ADDR_CTRL) ? i_wdata[KLI_CTRL_GLOBAL_EN] : g;
        // Set wins over a clear while the level persists
        next_fl = (fl & ~((i_wr && i_addr == KLI_ADDR_LINE_FLAGS) ? i_wdata[N-1:0] : '0)) | mt;
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            {sel, en, mt, fl, g, irq_r, wake_r} <= '0;
        end else begin
            sel <= next_sel;
            en <= next_en;
            g <= next_g;
            fl <= next_fl;
            mt <= ~(i_lines ^ sel);
            irq_r <= |(fl & en) & g;
            wake_r <= |(mt & en) & g;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    AST_RD_IDLE: assert property (!i_rd |=> o_rdata == KLI_READ_IDLE)
        else $error("read data not idle");
    AST_RD_FLAGS: assert property (i_rd && i_addr == KLI_ADDR_LINE_FLAGS |=> o_rdata == KLI_DW'($past(fl)))
        else $error("flag read wrong");
    AST_RD_SEL: assert property (i_rd && i_addr == KLI_ADDR_LEVEL_SEL |=> o_rdata == KLI_DW'($past(sel)))
        else $error("level select read wrong");
    AST_RD_EN: assert property (i_rd && i_addr == KLI_ADDR_LINE_EN |=> o_rdata == KLI_DW'($past(en)))
        else $error("enable read wrong");
    AST_RD_UNMAP: assert property (i_rd && !(i_addr inside {[KLI_ADDR_LEVEL_SEL:KLI_ADDR_LINE_STATE]})
        |=> o_rdata == KLI_READ_IDLE) else $error("unmapped read not zero");
    AST_IRQ: assert property (o_irq == irq_r) else $error("request wrong");
    AST_IRQ_GATE: assert property (!g && !$past(g) |-> !o_irq) else $error("request without global");
    AST_IRQ_MASK: assert property (en == '0 && $past(en) == '0 |-> !o_irq) else $error("masked request");
    AST_WAKE: assert property (o_wake == wake_r) else $error("wake wrong");
    AST_KEYMODE: assert property (en == $past(en) |-> o_key_mode == en) else $error("key mode wrong");
    AST_COV_IRQ: cover property ($rose(o_irq));
    AST_COV_WAKE: cover property ($rose(o_wake));
    AST_COV_HELD: cover property (i_wr && i_addr == KLI_ADDR_LINE_FLAGS && |(mt & i_wdata[N-1:0]));
endmodule
`default_nettype wire

// [kli_keypad_model.sv]
// Matrix keypad model: a pressed key pulls its port line low
`default_nettype none
module kli_keypad_model #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] i_press, // Pressed keys
    output logic      [N-1:0] o_lines  // Port lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines go to the pull-up level, never hold the last value
    assign o_lines = ~i_press;
endmodule
`default_nettype wire

// [tb_keypad_level_interrupt.sv]
// Self-checking bench for the keypad level interrupt unit
`default_nettype none
module tb_keypad_level_interrupt
    import kli_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, wr, rd;
    logic [7:0] addr, wdata, press, sel, en, c, m, exp_fl;
    wire  [7:0] lines, rdata, key_mode;
    wire        irq, wake;
    int         err_count, samples_checked, i, seed;
    kli_keypad_model kli_keypad_model_inst (.i_press(press), .o_lines(lines));
    kli_keypad_irq kli_keypad_irq_inst (.i_clk_sys(clk), .i_rst(rst), .i_lines(lines), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_wake(wake), .o_key_mode(key_mode));
    // ********
    // Tasks
    // ********
    function automatic logic [7:0] hit(input logic [7:0] ln, input logic [7:0] s);
        return ~(ln ^ s);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp, msg);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ********
    // Clock, watchdog, main sequence
    // ********
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata, press, exp_fl} = 34'h0;
        {err_count, samples_checked, seed} = {32'h0, 32'h0, 32'h68b1};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk({irq, wake}, 8'h00, "outputs after reset");
        rd_reg(KLI_ADDR_LEVEL_SEL, 8'h00, "select reset");
        rd_reg(KLI_ADDR_LINE_EN, 8'h00, "enable reset");
        rd_reg(KLI_ADDR_LINE_FLAGS, 8'h00, "flags reset");
        wr_reg(8'h9B, 8'hFF);
        rd_reg(8'h9B, 8'h00, "unmapped read");
        rd_reg(KLI_ADDR_LEVEL_SEL, 8'h00, "select kept");
        wr_reg(KLI_ADDR_CTRL, 8'h01);
        rd_reg(KLI_ADDR_CTRL, 8'h01, "global read");
        wr_reg(KLI_ADDR_LINE_STATE, 8'hFF);
        rd_reg(KLI_ADDR_LINE_STATE, 8'h00, "line state read only");
        for (i = 0; i < 24; i++) begin
            sel = (i == 0) ? 8'h00 : 8'($random(seed));
            en = (i == 1) ? 8'h00 : 8'($random(seed));
            c = (i == 2) ? 8'h00 : 8'($random(seed));
            wr_reg(KLI_ADDR_LEVEL_SEL, sel);
            rd_reg(KLI_ADDR_LEVEL_SEL, sel, "select");
            wr_reg(KLI_ADDR_LINE_EN, en);
            exp_fl = exp_fl | hit(~press, sel);
            @(posedge clk);
            press <= 8'($random(seed));
            @(posedge clk);
            m = hit(~press, sel);
            exp_fl = exp_fl | m;
            repeat (2) @(posedge clk);
            rd_reg(KLI_ADDR_LINE_FLAGS, exp_fl, "flags held");
            wr_reg(KLI_ADDR_LINE_FLAGS, c);
            exp_fl = (exp_fl & ~c) | m;
            rd_reg(KLI_ADDR_LINE_FLAGS, exp_fl, "flags cleared");
            rd_reg(KLI_ADDR_LINE_STATE, m, "line state");
            repeat (2) @(posedge clk);
            #1 chk(irq, |(exp_fl & en), "request");
            chk(wake, |(m & en), "wake");
            chk(key_mode, en, "key mode");
            if (i == 5) begin
                wr_reg(KLI_ADDR_CTRL, 8'h00);
                repeat (2) @(posedge clk);
                #1 chk({irq, wake}, 8'h00, "global off");
                wr_reg(KLI_ADDR_CTRL, 8'h01);
            end
        end
        // Second reset in mid-run, with every key released
        @(posedge clk);
        press <= 8'h00;
        rst   <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk({irq, wake}, 8'h00, "outputs after second reset");
        chk(key_mode, 8'h00, "key mode after second reset");
        rd_reg(KLI_ADDR_LEVEL_SEL, 8'h00, "select second reset");
        rd_reg(KLI_ADDR_LINE_EN, 8'h00, "enable second reset");
        rd_reg(KLI_ADDR_LINE_FLAGS, 8'h00, "flags second reset");
        rd_reg(KLI_ADDR_CTRL, 8'h00, "global second reset");
        print_verdict();
    end
endmodule
bind kli_keypad_irq kli_checker #(.N(N)) kli_checker_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_lines(i_lines), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_wake(o_wake), .o_key_mode(o_key_mode));
`default_nettype wire
